// >>> design/pcds_clock_ctrl.sv
`timescale 1ns/1ns
`include "pcds_map.svh"
// Summary of operation
// - bit 16 gates pin configuration bus clock
// - bit 17 gates CAN controller clock
// - bit 18 gates second serial port clock
// - serial port 0 divider, zero stops
// - UART divider, zero stops clock
// - serial port 1 divider, zero stops
// - watchdog source: RC, main, watchdog osc
// - watchdog source applied on 0-then-1 write
// - watchdog update bit, upper bits reserved
// - watchdog divider, zero disables watchdog clock
// - output source: RC, system, watchdog, main
// - output source applied on 0-then-1 write
// - output update bit, resets to zero
// - output divider, zero disables clock output
module pcds_clock_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic        internal_rc_oscillator,
  input  wire logic        sys_osc_clk,
  input  wire logic        wdt_osc_clk,
  output logic             pin_cfg_clk_en,
  output logic             can_clk_en,
  output logic             serial1_bus_clk_en,
  output logic             serial_port0_peripheral_clock,
  output logic             uart_pclk,
  output logic             serial_port1_peripheral_clock,
  output logic             wdt_pclk,
  output logic             clkout_pin
);

  pcds_pkg::pcds_state_t st;
  pcds_pkg::pcds_state_t next_st;

  logic [2:0] src_edge;
  logic       wdt_src;
  logic       out_src;
  logic [4:0] chan_src;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic wdt_source(input logic [1:0] sel, input logic [2:0] edges);
    case (sel)
      `PCDS_WDT_SRC_RC:    wdt_source = edges[0];
      `PCDS_WDT_SRC_MAIN:  wdt_source = 1'b1;
      `PCDS_WDT_SRC_WDOSC: wdt_source = edges[2];
      default:             wdt_source = 1'b0;
    endcase
  endfunction

  function automatic logic out_source(input logic [1:0] sel, input logic [2:0] edges);
    case (sel)
      `PCDS_OUT_SRC_RC:     out_source = edges[0];
      `PCDS_OUT_SRC_SYSOSC: out_source = edges[1];
      `PCDS_OUT_SRC_WDOSC:  out_source = edges[2];
      default:              out_source = 1'b1;
    endcase
  endfunction

  // period end: divider stopped, or last source tick of the period
  function automatic logic at_boundary(input logic [7:0] adiv, input logic [7:0] cnt, input logic src);
    at_boundary = (adiv == 8'h00) || (src && (cnt >= adiv - 8'h01));
  endfunction

  // --------------------------------------------------------------------------
  // source edge detect, after two-stage sync
  // --------------------------------------------------------------------------
  assign src_edge = st.sync2 & ~st.sync3;
  assign wdt_src  = wdt_source(st.wdt_act, src_edge);
  assign out_src  = out_source(st.out_act, src_edge);
  assign chan_src = {out_src, wdt_src, 3'h7};

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic bnd;
    bnd = 1'b0;
    next_st = st;
    next_st.sync1 = {wdt_osc_clk, sys_osc_clk, internal_rc_oscillator};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    next_st.rdata = 32'h0000_0000;

    for (int i = 0; i < 5; i++) begin
      bnd = at_boundary(st.act_div[i], st.cnt[i], chan_src[i]);
      next_st.tick[i] = 1'b0;
      if (st.act_div[i] != 8'h00 && chan_src[i]) begin
        if (st.cnt[i] >= st.act_div[i] - 8'h01) begin
          next_st.cnt[i]  = 8'h00;
          next_st.tick[i] = 1'b1;
        end else begin
          next_st.cnt[i] = st.cnt[i] + 8'h01;
        end
      end else if (st.act_div[i] == 8'h00) begin
        next_st.cnt[i] = 8'h00;
      end
      if (bnd) begin
        next_st.act_div[i] = st.div[i];
        if (i == 3 && st.wdt_pend) begin
          next_st.wdt_act  = st.wdt_sel;
          next_st.wdt_pend = 1'b0;
        end
        if (i == 4 && st.out_pend) begin
          next_st.out_act  = st.out_sel;
          next_st.out_pend = 1'b0;
        end
      end
    end

    if (wr_stb) begin
      case (addr)
        `PCDS_ADDR_BUS_CLOCK_GATES: begin
          next_st.gates = {wdata[`PCDS_GATE_SERIAL1_BIT], wdata[`PCDS_GATE_CAN_BIT],
                           wdata[`PCDS_GATE_PIN_CFG_BIT]};
        end
        `PCDS_ADDR_SERIAL_PORT0_DIV: next_st.div[0] = wdata[7:0];
        `PCDS_ADDR_UART_DIV:         next_st.div[1] = wdata[7:0];
        `PCDS_ADDR_SERIAL_PORT1_DIV: next_st.div[2] = wdata[7:0];
        `PCDS_ADDR_WDT_DIV:          next_st.div[3] = wdata[7:0];
        `PCDS_ADDR_OUT_DIV:          next_st.div[4] = wdata[7:0];
        `PCDS_ADDR_WDT_SOURCE_SELECT: next_st.wdt_sel = wdata[1:0];
        `PCDS_ADDR_OUT_SOURCE_SELECT: next_st.out_sel = wdata[1:0];
        `PCDS_ADDR_WDT_SOURCE_UPDATE: begin
          next_st.wdt_upd = wdata[0];
          if (wdata[0] && !st.wdt_upd) begin
            next_st.wdt_pend = 1'b1;
          end
        end
        `PCDS_ADDR_OUT_SOURCE_UPDATE: begin
          next_st.out_upd = wdata[0];
          if (wdata[0] && !st.out_upd) begin
            next_st.out_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (rd_stb) begin
      case (addr)
        `PCDS_ADDR_BUS_CLOCK_GATES: begin
          next_st.rdata[`PCDS_GATE_PIN_CFG_BIT] = st.gates[0];
          next_st.rdata[`PCDS_GATE_CAN_BIT]     = st.gates[1];
          next_st.rdata[`PCDS_GATE_SERIAL1_BIT] = st.gates[2];
        end
        `PCDS_ADDR_SERIAL_PORT0_DIV:  next_st.rdata[7:0] = st.div[0];
        `PCDS_ADDR_UART_DIV:          next_st.rdata[7:0] = st.div[1];
        `PCDS_ADDR_SERIAL_PORT1_DIV:  next_st.rdata[7:0] = st.div[2];
        `PCDS_ADDR_WDT_DIV:           next_st.rdata[7:0] = st.div[3];
        `PCDS_ADDR_OUT_DIV:           next_st.rdata[7:0] = st.div[4];
        `PCDS_ADDR_WDT_SOURCE_SELECT: next_st.rdata[1:0] = st.wdt_sel;
        `PCDS_ADDR_OUT_SOURCE_SELECT: next_st.rdata[1:0] = st.out_sel;
        `PCDS_ADDR_WDT_SOURCE_UPDATE: next_st.rdata[0]   = st.wdt_upd;
        `PCDS_ADDR_OUT_SOURCE_UPDATE: next_st.rdata[0]   = st.out_upd;
        `PCDS_ADDR_ACTIVE_STATUS: begin
          next_st.rdata[1:0] = st.wdt_act;
          next_st.rdata[`PCDS_STATUS_OUT_SEL_LSB +: 2] = st.out_act;
          next_st.rdata[`PCDS_STATUS_WDT_PEND_BIT]     = st.wdt_pend;
          next_st.rdata[`PCDS_STATUS_OUT_PEND_BIT]     = st.out_pend;
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.gates    <= `PCDS_RST_GATES;
      st.wdt_sel  <= `PCDS_RST_SEL;
      st.wdt_act  <= `PCDS_RST_SEL;
      st.out_sel  <= `PCDS_RST_SEL;
      st.out_act  <= `PCDS_RST_SEL;
      st.wdt_upd  <= `PCDS_RST_UPDATE;
      st.out_upd  <= `PCDS_RST_UPDATE;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign rdata                         = st.rdata;
  assign pin_cfg_clk_en                = st.gates[0];
  assign can_clk_en                    = st.gates[1];
  assign serial1_bus_clk_en            = st.gates[2];
  assign serial_port0_peripheral_clock = st.tick[0];
  assign uart_pclk                     = st.tick[1];
  assign serial_port1_peripheral_clock = st.tick[2];
  assign wdt_pclk                      = st.tick[3];
  assign clkout_pin                    = st.tick[4];

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_gate_pin_write: assert property (
    wr_stb && addr == `PCDS_ADDR_BUS_CLOCK_GATES |=> pin_cfg_clk_en == $past(wdata[16]))
    else $error("pin configuration gate not updated");
  a_gate_can_write: assert property (
    wr_stb && addr == `PCDS_ADDR_BUS_CLOCK_GATES |=> can_clk_en == $past(wdata[17]))
    else $error("CAN gate not updated");
  a_gate_serial1_write: assert property (
    wr_stb && addr == `PCDS_ADDR_BUS_CLOCK_GATES |=> serial1_bus_clk_en == $past(wdata[18]))
    else $error("serial 1 gate not updated");
  a_serial0_stopped: assert property (
    st.act_div[0] == 8'h00 |=> !serial_port0_peripheral_clock)
    else $error("serial 0 clock runs while stopped");
  a_uart_div_one: assert property (
    st.act_div[1] == 8'h01 && st.div[1] == 8'h01 |=> uart_pclk)
    else $error("uart divide by one not continuous");
  a_serial1_div_two: assert property (
    serial_port1_peripheral_clock && st.act_div[2] == 8'h02 && st.div[2] == 8'h02
    |=> !serial_port1_peripheral_clock ##1 serial_port1_peripheral_clock)
    else $error("serial 1 divide by two wrong");
  a_wdt_reserved_src: assert property (
    st.wdt_act == 2'h3 |-> !wdt_src)
    else $error("reserved watchdog source produced ticks");
  a_wdt_update_edge: assert property (
    wr_stb && addr == `PCDS_ADDR_WDT_SOURCE_UPDATE && wdata[0] && !st.wdt_upd |=> st.wdt_pend)
    else $error("watchdog update edge lost");
  a_wdt_no_edge: assert property (
    !st.wdt_pend && !(wr_stb && addr == `PCDS_ADDR_WDT_SOURCE_UPDATE) |=> $stable(st.wdt_act))
    else $error("watchdog source changed without update");
  a_wdt_update_bit: assert property (
    rd_stb && addr == `PCDS_ADDR_WDT_SOURCE_UPDATE |=> rdata[31:1] == 31'h0000_0000)
    else $error("reserved update bits not zero");
  a_wdt_stopped: assert property (
    st.act_div[3] == 8'h00 |=> !wdt_pclk)
    else $error("watchdog clock runs while disabled");
  a_out_main_src: assert property (
    st.out_act == `PCDS_OUT_SRC_MAIN |-> out_src)
    else $error("main clock source missing");
  a_out_no_edge: assert property (
    !st.out_pend && !(wr_stb && addr == `PCDS_ADDR_OUT_SOURCE_UPDATE) |=> $stable(st.out_act))
    else $error("output source changed without update");
  a_out_update_bit: assert property (
    wr_stb && addr == `PCDS_ADDR_OUT_SOURCE_UPDATE |=> st.out_upd == $past(wdata[0]))
    else $error("output update bit not stored");
  a_out_stopped: assert property (
    st.act_div[4] == 8'h00 |=> !clkout_pin)
    else $error("clock output runs while disabled");
  a_div_mid_period: assert property (
    st.act_div[1] != 8'h00 && !(st.cnt[1] >= st.act_div[1] - 8'h01) |=> $stable(st.act_div[1]))
    else $error("divider changed mid period");
  a_gate_pin_hold: assert property (
    !(wr_stb && addr == `PCDS_ADDR_BUS_CLOCK_GATES) |=> $stable(pin_cfg_clk_en))
    else $error("pin configuration gate changed without write");
  a_gate_can_hold: assert property (
    !(wr_stb && addr == `PCDS_ADDR_BUS_CLOCK_GATES) |=> $stable(can_clk_en))
    else $error("CAN gate changed without write");
  a_gate_serial1_hold: assert property (
    !(wr_stb && addr == `PCDS_ADDR_BUS_CLOCK_GATES) |=> $stable(serial1_bus_clk_en))
    else $error("serial 1 gate changed without write");
  a_serial0_div_one: assert property (
    st.act_div[0] == 8'h01 && st.div[0] == 8'h01 |=> serial_port0_peripheral_clock)
    else $error("serial 0 divide by one not continuous");
  a_serial0_mid_period: assert property (
    st.act_div[0] != 8'h00 && st.cnt[0] < st.act_div[0] - 8'h01 |=> $stable(st.act_div[0]))
    else $error("serial 0 divider changed mid period");
  a_uart_stopped: assert property (
    st.act_div[1] == 8'h00 |=> !uart_pclk)
    else $error("uart clock runs while stopped");
  a_serial1_stopped: assert property (
    st.act_div[2] == 8'h00 |=> !serial_port1_peripheral_clock)
    else $error("serial 1 clock runs while stopped");
  a_wdt_main_src: assert property (
    st.wdt_act == `PCDS_WDT_SRC_MAIN |-> wdt_src)
    else $error("watchdog main clock source missing");
  a_wdt_sel_store: assert property (
    wr_stb && addr == `PCDS_ADDR_WDT_SOURCE_SELECT |=> st.wdt_sel == $past(wdata[1:0]))
    else $error("watchdog source select not stored");
  a_wdt_sel_read: assert property (
    rd_stb && addr == `PCDS_ADDR_WDT_SOURCE_SELECT |=> rdata == {30'h0000_0000, $past(st.wdt_sel)})
    else $error("watchdog source select read wrong");
  a_wdt_apply: assert property (
    st.wdt_pend && at_boundary(st.act_div[3], st.cnt[3], wdt_src) |=> st.wdt_act == $past(st.wdt_sel))
    else $error("pending watchdog source not applied");
  a_wdt_upd_store: assert property (
    wr_stb && addr == `PCDS_ADDR_WDT_SOURCE_UPDATE |=> st.wdt_upd == $past(wdata[0]))
    else $error("watchdog update bit not stored");
  a_wdt_div_tick: assert property (
    wdt_pclk |-> $past(st.act_div[3]) != 8'h00)
    else $error("watchdog clock ticked while disabled");
  a_wdt_mid_period: assert property (
    !at_boundary(st.act_div[3], st.cnt[3], wdt_src) |=> $stable(st.wdt_act) && $stable(st.act_div[3]))
    else $error("watchdog source or divider changed mid period");
  a_out_sel_store: assert property (
    wr_stb && addr == `PCDS_ADDR_OUT_SOURCE_SELECT |=> st.out_sel == $past(wdata[1:0]))
    else $error("output source select not stored");
  a_out_sel_read: assert property (
    rd_stb && addr == `PCDS_ADDR_OUT_SOURCE_SELECT |=> rdata == {30'h0000_0000, $past(st.out_sel)})
    else $error("output source select read wrong");
  a_out_update_edge: assert property (
    wr_stb && addr == `PCDS_ADDR_OUT_SOURCE_UPDATE && wdata[0] && !st.out_upd |=> st.out_pend)
    else $error("output update edge lost");
  a_out_apply: assert property (
    st.out_pend && at_boundary(st.act_div[4], st.cnt[4], out_src) |=> st.out_act == $past(st.out_sel))
    else $error("pending output source not applied");
  a_out_upd_read: assert property (
    rd_stb && addr == `PCDS_ADDR_OUT_SOURCE_UPDATE |=> rdata == {31'h0000_0000, $past(st.out_upd)})
    else $error("output update bit read wrong");
  a_out_div_tick: assert property (
    clkout_pin |-> $past(st.act_div[4]) != 8'h00)
    else $error("clock output ticked while disabled");
  a_clkout_div_one: assert property (
    st.act_div[4] == 8'h01 && st.out_act == `PCDS_OUT_SRC_MAIN |=> clkout_pin)
    else $error("clock output divide by one not continuous");
  a_out_mid_period: assert property (
    !at_boundary(st.act_div[4], st.cnt[4], out_src) |=> $stable(st.out_act) && $stable(st.act_div[4]))
    else $error("output source or divider changed mid period");

  // --------------------------------------------------------------------------
  // cover points
  // --------------------------------------------------------------------------
  c_uart_tick: cover property (uart_pclk);
  c_wdt_switch: cover property (st.wdt_pend ##[1:300] !st.wdt_pend);
  c_out_switch: cover property (st.out_pend ##[1:300] !st.out_pend);
  c_clkout_tick: cover property (clkout_pin && st.out_act == `PCDS_OUT_SRC_SYSOSC);
  c_serial1_stop: cover property (serial_port1_peripheral_clock ##1 st.act_div[2] == 8'h00);

endmodule // pcds_clock_ctrl

// >>> design/pcds_map.svh
`ifndef PCDS_MAP_SVH
`define PCDS_MAP_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define PCDS_ADDR_BUS_CLOCK_GATES        32'h4004_8080
`define PCDS_ADDR_SERIAL_PORT0_DIV       32'h4004_8094
`define PCDS_ADDR_UART_DIV               32'h4004_8098
`define PCDS_ADDR_SERIAL_PORT1_DIV       32'h4004_809C
`define PCDS_ADDR_WDT_SOURCE_SELECT      32'h4004_80D0
`define PCDS_ADDR_WDT_SOURCE_UPDATE      32'h4004_80D4
`define PCDS_ADDR_WDT_DIV                32'h4004_80D8
`define PCDS_ADDR_OUT_SOURCE_SELECT      32'h4004_80E0
`define PCDS_ADDR_OUT_SOURCE_UPDATE      32'h4004_80E4
`define PCDS_ADDR_OUT_DIV                32'h4004_80E8
`define PCDS_ADDR_ACTIVE_STATUS          32'h4004_80F0

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PCDS_GATE_PIN_CFG_BIT            16
`define PCDS_GATE_CAN_BIT                17
`define PCDS_GATE_SERIAL1_BIT            18
`define PCDS_STATUS_OUT_SEL_LSB          2
`define PCDS_STATUS_WDT_PEND_BIT         4
`define PCDS_STATUS_OUT_PEND_BIT         5

// ----------------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------------
`define PCDS_RST_GATES                   3'h0
`define PCDS_RST_DIV                     8'h00
`define PCDS_RST_SEL                     2'h0
`define PCDS_RST_UPDATE                  1'h0
`define PCDS_WDT_SRC_RC                  2'h0
`define PCDS_WDT_SRC_MAIN                2'h1
`define PCDS_WDT_SRC_WDOSC               2'h2
`define PCDS_OUT_SRC_RC                  2'h0
`define PCDS_OUT_SRC_SYSOSC              2'h1
`define PCDS_OUT_SRC_WDOSC               2'h2
`define PCDS_OUT_SRC_MAIN                2'h3

`endif

// >>> design/pcds_pkg.sv
package pcds_pkg;

  // channel order of the five dividers
  typedef enum logic [2:0] {
    PCDS_CH_SERIAL0,
    PCDS_CH_UART,
    PCDS_CH_SERIAL1,
    PCDS_CH_WDT,
    PCDS_CH_OUT
  } pcds_chan_t;

  typedef struct packed {
    logic [2:0]      gates;
    logic [4:0][7:0] div;
    logic [4:0][7:0] act_div;
    logic [4:0][7:0] cnt;
    logic [4:0]      tick;
    logic [1:0]      wdt_sel;
    logic [1:0]      wdt_act;
    logic            wdt_upd;
    logic            wdt_pend;
    logic [1:0]      out_sel;
    logic [1:0]      out_act;
    logic            out_upd;
    logic            out_pend;
    logic [2:0]      sync1;
    logic [2:0]      sync2;
    logic [2:0]      sync3;
    logic [31:0]     rdata;
  } pcds_state_t;

endpackage

// >>> sim/pcds_clock_ctrl_bench.sv
`timescale 1ns/1ns
`include "pcds_map.svh"
module pcds_clock_ctrl_bench;
  logic        ref_clk;
  logic        rst_n;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic        rc_osc = 1'h0;
  logic        sys_osc = 1'h0;
  logic        wdt_osc = 1'h0;
  logic [2:0]  gate_en;
  logic [4:0]  pclk;
  logic [31:0] got;
  logic [31:0] d;
  logic [7:0]  n;
  int          cyc = 0;
  int          err_count;
  int          cmp_count;

  localparam logic [31:0] REG_ADDR [11] = '{`PCDS_ADDR_BUS_CLOCK_GATES, `PCDS_ADDR_SERIAL_PORT0_DIV,
    `PCDS_ADDR_UART_DIV, `PCDS_ADDR_SERIAL_PORT1_DIV, `PCDS_ADDR_WDT_SOURCE_SELECT, `PCDS_ADDR_WDT_SOURCE_UPDATE,
    `PCDS_ADDR_WDT_DIV, `PCDS_ADDR_OUT_SOURCE_SELECT, `PCDS_ADDR_OUT_SOURCE_UPDATE, `PCDS_ADDR_OUT_DIV,
    `PCDS_ADDR_ACTIVE_STATUS};

  pcds_clock_ctrl pcds_clock_ctrl_i (
    .ref_clk                       (ref_clk),
    .rst_n                         (rst_n),
    .addr                          (addr),
    .wdata                         (wdata),
    .wr_stb                        (wr_stb),
    .rd_stb                        (rd_stb),
    .rdata                         (rdata),
    .internal_rc_oscillator        (rc_osc),
    .sys_osc_clk                   (sys_osc),
    .wdt_osc_clk                   (wdt_osc),
    .pin_cfg_clk_en                (gate_en[0]),
    .can_clk_en                    (gate_en[1]),
    .serial1_bus_clk_en            (gate_en[2]),
    .serial_port0_peripheral_clock (pclk[0]),
    .uart_pclk                     (pclk[1]),
    .serial_port1_peripheral_clock (pclk[2]),
    .wdt_pclk                      (pclk[3]),
    .clkout_pin                    (pclk[4])
  );

  // ----------------------------------------------------------------------------
  // clock and oscillators
  // ----------------------------------------------------------------------------
  initial ref_clk = 1'h0;
  always #5 ref_clk = ~ref_clk;

  // rising edges every 6, 8 and 10 cycles, never stopped
  always @(posedge ref_clk) begin
    cyc     <= cyc + 1;
    rc_osc  <= (cyc % 6) < 3;
    sys_osc <= (cyc % 8) < 4;
    wdt_osc <= (cyc % 10) < 5;
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic print_verdict;
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    wr_stb <= 1'h1;
    addr   <= a;
    wdata  <= v;
    @(posedge ref_clk);
    wr_stb <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string what);
    rd_stb <= 1'h1;
    addr   <= a;
    @(posedge ref_clk);
    rd_stb <= 1'h0;
    @(posedge ref_clk);
    got = rdata;
    check(got, e, what);
  endtask

  // cycles between source ticks; 0 means no ticks
  function automatic int src_period(input int w, input logic [1:0] s);
    if (w != 0) return (s == 2'h0) ? 6 : (s == 2'h1) ? 1 : (s == 2'h2) ? 10 : 0;
    return (s == 2'h0) ? 6 : (s == 2'h1) ? 8 : (s == 2'h2) ? 10 : 1;
  endfunction

  // long settle so that any old period has run out first
  task automatic chk_rate(input int ch, input int per, input int div, input string what);
    int c;
    idle(600);
    c = 0;
    repeat ((per == 0 || div == 0) ? 300 : 4 * per * div) begin
      @(posedge ref_clk);
      if (pclk[ch] !== 1'h0) c++;
    end
    check(c, (per == 0 || div == 0) ? 0 : 4, what);
  endtask

  task automatic src_test(input int w, input logic [31:0] sel_a, input logic [31:0] upd_a,
                          input logic [31:0] div_a);
    int         ch;
    logic [1:0] s;
    logic [7:0] k;
    ch = (w != 0) ? 3 : 4;
    k  = 8'($urandom_range(1, 4));
    wr(div_a, {24'h0, k});
    wr(upd_a, 32'h0);
    wr(upd_a, 32'hFFFF_FFFF);
    rd_chk(upd_a, 32'h1, "update bit readback");
    chk_rate(ch, 6, int'(k), "rc source rate");
    wr(sel_a, 32'h1);
    wr(upd_a, 32'h1);
    chk_rate(ch, 6, int'(k), "update without low write");
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(sel_a, {30'($urandom), s});
      rd_chk(sel_a, {30'h0, s}, "source select readback");
      chk_rate(ch, src_period(w, (i == 0) ? 2'h0 : 2'(i - 1)), int'(k), "before update");
      wr(upd_a, 32'h0);
      wr(upd_a, 32'h1);
      chk_rate(ch, src_period(w, s), int'(k), "selected source rate");
      rd_chk(`PCDS_ADDR_ACTIVE_STATUS, (w != 0) ? {30'h0, s} : {28'h0, s, 2'h3}, "active source");
    end
    wr(div_a, 32'h0);
    chk_rate(ch, 1, 0, "divider zero stops clock");
  endtask

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    // run budget of 60k cycles
    #600000;
    err_count++;
    print_verdict;
  end

  initial begin
    rst_n     = 1'h0;
    addr      = 32'h0;
    wdata     = 32'h0;
    wr_stb    = 1'h0;
    rd_stb    = 1'h0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(32'h132F791D));
    idle(10);
    check({24'h0, pclk, gate_en}, 32'h0, "outputs in reset");
    rst_n <= 1'h1;
    @(posedge ref_clk);
    foreach (REG_ADDR[i]) begin
      rd_chk(REG_ADDR[i], 32'h0, "reset");
    end
    wr(32'h4004_8090, 32'hFFFF_FFFF);
    rd_chk(32'h4004_8090, 32'h0, "unmapped read");
    // bus clock gates, corners then random
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'h0007_0000 : (i == 1) ? 32'hFFF8_FFFF : $urandom;
      wr(`PCDS_ADDR_BUS_CLOCK_GATES, d);
      rd_chk(`PCDS_ADDR_BUS_CLOCK_GATES, d & 32'h0007_0000, "gate readback");
      check({29'h0, gate_en}, {29'h0, d[18:16]}, "gate outputs");
    end
    // pin configuration clock on before any uart divider
    wr(`PCDS_ADDR_BUS_CLOCK_GATES, 32'h0001_0000);
    // main clock dividers: corners 1, 255, 0 and random
    for (int ch = 0; ch < 3; ch++) begin
      for (int j = 0; j < 5; j++) begin
        n = (j == 0) ? 8'h01 : (j == 1) ? 8'hFF : (j == 2) ? 8'h00 : 8'($urandom_range(2, 16));
        wr(REG_ADDR[ch + 1], {24'($urandom), n});
        rd_chk(REG_ADDR[ch + 1], {24'h0, n}, "divider readback");
        chk_rate(ch, 1, int'(n), "divided main clock");
      end
    end
    src_test(1, `PCDS_ADDR_WDT_SOURCE_SELECT, `PCDS_ADDR_WDT_SOURCE_UPDATE, `PCDS_ADDR_WDT_DIV);
    src_test(0, `PCDS_ADDR_OUT_SOURCE_SELECT, `PCDS_ADDR_OUT_SOURCE_UPDATE, `PCDS_ADDR_OUT_DIV);
    print_verdict;
  end
endmodule // pcds_clock_ctrl_bench
